// file: logic/pmc_pkg.sv
// Shared constants and types of the power-mode controller
package pmc_pkg;

	// ==========================================
	// Timing
	localparam int REF_CLK_MHZ = 100;
	localparam int OSC_STABLE_US = 50;
	localparam int OSC_STABLE_CYC = OSC_STABLE_US * REF_CLK_MHZ;

	// ==========================================
	// Widths and source counts
	localparam int PIN_N = 6;
	localparam int SER_N = 9;
	localparam int TMR_N = 11;
	localparam int FLAGS_W = 16;
	localparam int PC_W = 20;
	localparam int PRIO_W = 3;
	localparam int INUM_W = 6;

	// ==========================================
	// Flag register fields
	localparam int FLAGS_D_BIT = 2;
	localparam int FLAGS_I_BIT = 6;
	localparam int FLAGS_U_BIT = 7;

	// ==========================================
	// Interrupt entry
	localparam logic [PC_W-1:0] ACK_ADDR = 20'h00000;
	localparam logic [INUM_W-1:0] SW_INT_FIRST = 6'h20;
	localparam logic [INUM_W-1:0] SW_INT_LAST = 6'h3F;

	// ==========================================
	// Divider limits (divisor minus one)
	localparam logic [3:0] LIM_DIV1 = 4'h0;
	localparam logic [3:0] LIM_DIV2 = 4'h1;
	localparam logic [3:0] LIM_DIV4 = 4'h3;
	localparam logic [3:0] LIM_DIV8 = 4'h7;
	localparam logic [3:0] LIM_DIV16 = 4'hF;

	// ==========================================
	// Reset values
	localparam logic RST_DIV8 = 1'b1;
	localparam logic RST_RATIO_LOW = 1'b0;
	localparam logic RST_RATIO_HIGH = 1'b0;
	localparam logic RST_SOURCE = 1'b0;
	localparam logic RST_WAIT_PCS = 1'b0;
	localparam logic RST_MAIN_STOP = 1'b0;
	localparam logic RST_MAIN_DRIVE = 1'b1;
	localparam logic RST_SUB_DRIVE = 1'b1;

	typedef enum logic [3:0] {
		PMC_RUN, PMC_WAIT, PMC_STOP, PMC_OSC, PMC_ACK,
		PMC_SAVE, PMC_CLR, PMC_PUSHF, PMC_PUSHPC, PMC_PRIO
	} pmc_state_t;

endpackage

// file: logic/pmc_sync3.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/100ps
module pmc_sync3 #(
	parameter int W = 2
) (
	// Clocking
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Data
	input wire logic [W-1:0] pin_in,
	input wire logic [W-1:0] rst_val,
	output logic [W-1:0] level_out
);

	// ==========================================
	// Per-bit stages
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic lvl_reg;
			// Reset loads a constant per bit; the rst_val port is tied at the instance
			always_ff @(posedge clk) begin
				if (reset) begin
					s1_reg <= rst_val[i];
					s2_reg <= rst_val[i];
					s3_reg <= rst_val[i];
					lvl_reg <= rst_val[i];
				end else if (clk_en) begin
					s1_reg <= pin_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						lvl_reg <= s3_reg;
					end
				end
			end
			assign level_out[i] = lvl_reg;
		end
	endgenerate

endmodule // pmc_sync3

// file: logic/pmc_ctrl.sv
// Power-mode controller: clock source, low-power modes, wake-up and entry
`timescale 1ns/100ps
module pmc_ctrl #(
	parameter int OSC_STABLE_CYCLES = pmc_pkg::OSC_STABLE_CYC
) (
	// Clocking and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic CLK_EN,
	// Pins
	input wire logic SUBCLOCK_SIGNAL,
	input wire logic NMI_N,
	// Clock configuration from software
	input wire logic CLK_CFG_WR,
	input wire logic CFG_SOURCE_SELECT,
	input wire logic CFG_DIV8_SELECT,
	input wire logic CFG_RATIO_LOW,
	input wire logic CFG_RATIO_HIGH,
	input wire logic CFG_WAIT_PCS,
	input wire logic CFG_MAIN_STOP,
	input wire logic CFG_MAIN_DRIVE,
	input wire logic CFG_SUB_DRIVE,
	// Mode commands
	input wire logic WAIT_CMD,
	input wire logic STOP_CMD,
	// Wake sources
	input wire logic [pmc_pkg::PIN_N-1:0] INT_PIN_REQ,
	input wire logic KEY_REQ,
	input wire logic [pmc_pkg::SER_N-1:0] SERIAL_REQ,
	input wire logic [pmc_pkg::SER_N-1:0] SERIAL_EXT_CLK,
	input wire logic [pmc_pkg::TMR_N-1:0] TIMER_REQ,
	input wire logic [pmc_pkg::TMR_N-1:0] TIMER_EXT_EVENT,
	input wire logic AD_REQ,
	input wire logic AD_ONE_SHOT,
	// CPU entry data
	input wire logic [pmc_pkg::INUM_W-1:0] ACK_NUM,
	input wire logic [pmc_pkg::PRIO_W-1:0] ACK_LEVEL,
	input wire logic SW_INT,
	input wire logic [pmc_pkg::FLAGS_W-1:0] FLAGS_IN,
	input wire logic [pmc_pkg::PC_W-1:0] PC_IN,
	// Clock outputs
	output logic BCLK_EN,
	output logic CPU_HALT,
	output logic MAIN_OSC_EN,
	output logic SUB_OSC_EN,
	output logic PERIPH_CLK_EN,
	output logic SUB_PERIPH_CLK_EN,
	output logic MAIN_DRIVE_HIGH,
	output logic SUB_DRIVE_HIGH,
	// Status
	output logic ALL_CLOCK_STOP_CONTROL,
	output logic MAIN_DIV8_SELECT,
	output logic MAIN_DIVIDE_RATIO_LOW,
	output logic MAIN_DIVIDE_RATIO_HIGH,
	output logic SYSTEM_CLOCK_SOURCE_SELECT,
	output logic WAIT_PERIPH_CLOCK_STOP,
	// Entry outputs
	output logic ACK_RD,
	output logic [pmc_pkg::PC_W-1:0] ACK_ADDR,
	output logic FLAGS_WR,
	output logic [pmc_pkg::FLAGS_W-1:0] FLAGS_OUT,
	output logic STACK_WR,
	output logic [pmc_pkg::PC_W-1:0] STACK_DATA,
	output logic PRIO_WR,
	output logic [pmc_pkg::PRIO_W-1:0] PRIO_OUT,
	output logic FETCH_START
);

	localparam int OSC_W = $clog2(OSC_STABLE_CYCLES + 1);
	localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_STABLE_CYCLES - 1);

	pmc_pkg::pmc_state_t state_reg;
	pmc_pkg::pmc_state_t state_next;

	logic div8_reg;
	logic ratio_low_reg;
	logic ratio_high_reg;
	logic source_reg;
	logic wait_pcs_reg;
	logic main_stop_reg;
	logic [3:0] div_cnt_reg;
	logic [3:0] div_lim;
	logic main_tick;
	logic sub_prev_reg;
	logic sub_rise;
	logic [1:0] pin_lvl;
	logic nmi_low;
	logic stop_go;
	logic gated;
	logic wake;
	logic [OSC_W-1:0] osc_cnt_reg;
	logic [pmc_pkg::INUM_W-1:0] num_reg;
	logic [pmc_pkg::PRIO_W-1:0] lvl_reg;
	logic [pmc_pkg::FLAGS_W-1:0] tmp_flags_reg;
	logic keep_u;
	logic cpu_runs;

	// ==========================================
	// Pin synchronisers
	pmc_sync3 #(
		.W(2)
	) u_sync (
		.clk(REF_CLK),
		.reset(RESET),
		.clk_en(CLK_EN),
		.pin_in({NMI_N, SUBCLOCK_SIGNAL}),
		.rst_val(2'h2),
		.level_out(pin_lvl)
	);

	assign nmi_low = ~pin_lvl[1];
	// A low non-maskable pin blocks stop entry so that request is never lost
	assign stop_go = STOP_CMD & ~nmi_low;

	// ==========================================
	// Clock configuration bits
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			div8_reg <= pmc_pkg::RST_DIV8;
			ratio_low_reg <= pmc_pkg::RST_RATIO_LOW;
			ratio_high_reg <= pmc_pkg::RST_RATIO_HIGH;
			source_reg <= pmc_pkg::RST_SOURCE;
			wait_pcs_reg <= pmc_pkg::RST_WAIT_PCS;
			main_stop_reg <= pmc_pkg::RST_MAIN_STOP;
		end else if (CLK_EN) begin
			if (CLK_CFG_WR && state_reg == pmc_pkg::PMC_RUN) begin
				div8_reg <= CFG_DIV8_SELECT;
				ratio_low_reg <= CFG_RATIO_LOW;
				ratio_high_reg <= CFG_RATIO_HIGH;
				source_reg <= CFG_SOURCE_SELECT;
				wait_pcs_reg <= CFG_WAIT_PCS;
				// Main may only stop while the CPU runs from the sub-clock
				main_stop_reg <= CFG_MAIN_STOP & CFG_SOURCE_SELECT;
			end
			// Forced set wins over a write in the same cycle
			if (state_reg == pmc_pkg::PMC_RUN && stop_go && !source_reg) begin
				div8_reg <= 1'b1;
			end
			// On the sub-clock the divide-by-8 bit is left alone at stop entry
		end
	end

	// ==========================================
	// Drive strength
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			MAIN_DRIVE_HIGH <= pmc_pkg::RST_MAIN_DRIVE;
			SUB_DRIVE_HIGH <= pmc_pkg::RST_SUB_DRIVE;
		end else if (CLK_EN) begin
			if (CLK_CFG_WR && state_reg == pmc_pkg::PMC_RUN) begin
				MAIN_DRIVE_HIGH <= CFG_MAIN_DRIVE;
				SUB_DRIVE_HIGH <= CFG_SUB_DRIVE;
			end
			// Sub oscillator restarts at full drive after stop
			if (state_reg == pmc_pkg::PMC_RUN && stop_go) begin
				SUB_DRIVE_HIGH <= 1'b1;
			end
		end
	end

	// ==========================================
	// Main clock divider
	always_comb begin
		if (div8_reg) begin
			div_lim = pmc_pkg::LIM_DIV8;
		end else begin
			unique case ({ratio_high_reg, ratio_low_reg})
				2'h0: div_lim = pmc_pkg::LIM_DIV1;
				2'h1: div_lim = pmc_pkg::LIM_DIV2;
				2'h2: div_lim = pmc_pkg::LIM_DIV4;
				2'h3: div_lim = pmc_pkg::LIM_DIV16;
			endcase
		end
	end

	assign main_tick = (div_cnt_reg >= div_lim);

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			div_cnt_reg <= 4'h0;
		end else if (CLK_EN) begin
			if (main_tick) begin
				div_cnt_reg <= 4'h0;
			end else begin
				div_cnt_reg <= div_cnt_reg + 4'h1;
			end
		end
	end

	// ==========================================
	// Sub-clock edge
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			sub_prev_reg <= 1'b0;
		end else if (CLK_EN) begin
			sub_prev_reg <= pin_lvl[0];
		end
	end

	assign sub_rise = pin_lvl[0] & ~sub_prev_reg;

	// ==========================================
	// Wake source qualification
	// Gated: main peripheral clock stopped, so only externally clocked units can wake
	assign gated = (state_reg != pmc_pkg::PMC_WAIT) | wait_pcs_reg;

	always_comb begin
		wake = (|INT_PIN_REQ) | nmi_low | KEY_REQ;
		if (gated) begin
			wake = wake | (|(SERIAL_REQ & SERIAL_EXT_CLK));
			wake = wake | (|(TIMER_REQ & TIMER_EXT_EVENT));
		end else begin
			wake = wake | (|SERIAL_REQ) | (|TIMER_REQ);
			wake = wake | (AD_REQ & AD_ONE_SHOT);
		end
	end

	// ==========================================
	// Mode sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			pmc_pkg::PMC_RUN: begin
				if (stop_go) begin
					state_next = pmc_pkg::PMC_STOP;
				end else if (WAIT_CMD) begin
					state_next = pmc_pkg::PMC_WAIT;
				end
			end
			pmc_pkg::PMC_WAIT: begin
				// Clock selection is untouched, so it resumes as it was
				if (wake) begin
					state_next = pmc_pkg::PMC_ACK;
				end
			end
			pmc_pkg::PMC_STOP: begin
				if (wake) begin
					state_next = pmc_pkg::PMC_OSC;
				end
			end
			pmc_pkg::PMC_OSC: begin
				if (osc_cnt_reg == OSC_LAST) begin
					state_next = pmc_pkg::PMC_ACK;
				end
			end
			pmc_pkg::PMC_ACK: state_next = pmc_pkg::PMC_SAVE;
			pmc_pkg::PMC_SAVE: state_next = pmc_pkg::PMC_CLR;
			pmc_pkg::PMC_CLR: state_next = pmc_pkg::PMC_PUSHF;
			pmc_pkg::PMC_PUSHF: state_next = pmc_pkg::PMC_PUSHPC;
			pmc_pkg::PMC_PUSHPC: state_next = pmc_pkg::PMC_PRIO;
			pmc_pkg::PMC_PRIO: state_next = pmc_pkg::PMC_RUN;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state_reg <= pmc_pkg::PMC_RUN;
		end else if (CLK_EN) begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Oscillation start-up timer
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			osc_cnt_reg <= '0;
		end else if (CLK_EN) begin
			if (state_reg != pmc_pkg::PMC_OSC) begin
				osc_cnt_reg <= '0;
			end else begin
				osc_cnt_reg <= osc_cnt_reg + OSC_W'(1);
			end
		end
	end

	// ==========================================
	// Oscillator and clock gating
	assign cpu_runs = state_next != pmc_pkg::PMC_WAIT && state_next != pmc_pkg::PMC_STOP
		&& state_next != pmc_pkg::PMC_OSC;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			BCLK_EN <= 1'b0;
			CPU_HALT <= 1'b0;
			MAIN_OSC_EN <= 1'b1;
			SUB_OSC_EN <= 1'b1;
			PERIPH_CLK_EN <= 1'b1;
			SUB_PERIPH_CLK_EN <= 1'b1;
		end else if (CLK_EN) begin
			BCLK_EN <= cpu_runs & (source_reg ? sub_rise : main_tick);
			CPU_HALT <= ~cpu_runs;
			MAIN_OSC_EN <= (state_next != pmc_pkg::PMC_STOP) & ~main_stop_reg;
			SUB_OSC_EN <= state_next != pmc_pkg::PMC_STOP;
			PERIPH_CLK_EN <= ~main_stop_reg & (cpu_runs
				| (state_next == pmc_pkg::PMC_WAIT & ~wait_pcs_reg));
			SUB_PERIPH_CLK_EN <= state_next != pmc_pkg::PMC_STOP
				&& state_next != pmc_pkg::PMC_OSC;
		end
	end

	// ==========================================
	// All-clock-stop control bit
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ALL_CLOCK_STOP_CONTROL <= 1'b0;
		end else if (CLK_EN) begin
			if (state_reg == pmc_pkg::PMC_RUN && stop_go) begin
				ALL_CLOCK_STOP_CONTROL <= 1'b1;
			end else if (state_reg == pmc_pkg::PMC_STOP && wake) begin
				ALL_CLOCK_STOP_CONTROL <= 1'b0;
			end
		end
	end

	// ==========================================
	// Status mirror
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			MAIN_DIV8_SELECT <= pmc_pkg::RST_DIV8;
			MAIN_DIVIDE_RATIO_LOW <= pmc_pkg::RST_RATIO_LOW;
			MAIN_DIVIDE_RATIO_HIGH <= pmc_pkg::RST_RATIO_HIGH;
			SYSTEM_CLOCK_SOURCE_SELECT <= pmc_pkg::RST_SOURCE;
			WAIT_PERIPH_CLOCK_STOP <= pmc_pkg::RST_WAIT_PCS;
		end else if (CLK_EN) begin
			MAIN_DIV8_SELECT <= div8_reg;
			MAIN_DIVIDE_RATIO_LOW <= ratio_low_reg;
			MAIN_DIVIDE_RATIO_HIGH <= ratio_high_reg;
			SYSTEM_CLOCK_SOURCE_SELECT <= source_reg;
			WAIT_PERIPH_CLOCK_STOP <= wait_pcs_reg;
		end
	end

	// ==========================================
	// Interrupt entry data path
	// Software numbers 32..63 keep the stack flag
	assign keep_u = SW_INT && num_reg >= pmc_pkg::SW_INT_FIRST
		&& num_reg <= pmc_pkg::SW_INT_LAST;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			num_reg <= '0;
			lvl_reg <= '0;
			tmp_flags_reg <= '0;
		end else if (CLK_EN) begin
			if (state_reg == pmc_pkg::PMC_ACK) begin
				num_reg <= ACK_NUM;
				lvl_reg <= ACK_LEVEL;
			end
			if (state_reg == pmc_pkg::PMC_SAVE) begin
				tmp_flags_reg <= FLAGS_IN;
			end
		end
	end

	// ==========================================
	// Entry strobes
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ACK_RD <= 1'b0;
			ACK_ADDR <= pmc_pkg::ACK_ADDR;
			FLAGS_WR <= 1'b0;
			FLAGS_OUT <= '0;
			STACK_WR <= 1'b0;
			STACK_DATA <= '0;
			PRIO_WR <= 1'b0;
			PRIO_OUT <= '0;
			FETCH_START <= 1'b0;
		end else if (CLK_EN) begin
			ACK_RD <= state_next == pmc_pkg::PMC_ACK;
			FLAGS_WR <= state_reg == pmc_pkg::PMC_CLR;
			STACK_WR <= state_reg == pmc_pkg::PMC_PUSHF
				|| state_reg == pmc_pkg::PMC_PUSHPC;
			PRIO_WR <= state_reg == pmc_pkg::PMC_PRIO;
			FETCH_START <= state_reg == pmc_pkg::PMC_PRIO;
			if (state_reg == pmc_pkg::PMC_CLR) begin
				FLAGS_OUT <= tmp_flags_reg;
				FLAGS_OUT[pmc_pkg::FLAGS_I_BIT] <= 1'b0;
				FLAGS_OUT[pmc_pkg::FLAGS_D_BIT] <= 1'b0;
				FLAGS_OUT[pmc_pkg::FLAGS_U_BIT] <= tmp_flags_reg[pmc_pkg::FLAGS_U_BIT] & keep_u;
			end
			if (state_reg == pmc_pkg::PMC_PUSHF) begin
				STACK_DATA <= {{(pmc_pkg::PC_W - pmc_pkg::FLAGS_W){1'b0}},
					tmp_flags_reg};
			end else if (state_reg == pmc_pkg::PMC_PUSHPC) begin
				STACK_DATA <= PC_IN;
			end
			if (state_reg == pmc_pkg::PMC_PRIO) begin
				PRIO_OUT <= lvl_reg;
			end
		end
	end

endmodule // pmc_ctrl

// file: test/pmc_ctrl_sva.sv
// Concurrent checks on the ports of the power-mode controller
`timescale 1ns/100ps
module pmc_ctrl_sva #(
	parameter int OSC_STABLE_CYCLES = 4
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// Inputs watched
	input wire logic NMI_N,
	input wire logic CLK_CFG_WR,
	input wire logic CFG_RATIO_LOW,
	input wire logic [5:0] INT_PIN_REQ,
	input wire logic KEY_REQ,
	input wire logic [8:0] SERIAL_REQ,
	input wire logic [8:0] SERIAL_EXT_CLK,
	input wire logic [10:0] TIMER_REQ,
	input wire logic [10:0] TIMER_EXT_EVENT,
	// Clock outputs
	input wire logic BCLK_EN,
	input wire logic CPU_HALT,
	input wire logic MAIN_OSC_EN,
	input wire logic SUB_OSC_EN,
	input wire logic PERIPH_CLK_EN,
	input wire logic ALL_CLOCK_STOP_CONTROL,
	input wire logic MAIN_DIV8_SELECT,
	input wire logic MAIN_DIVIDE_RATIO_LOW,
	input wire logic SYSTEM_CLOCK_SOURCE_SELECT,
	// Entry outputs
	input wire logic ACK_RD,
	input wire logic [19:0] ACK_ADDR,
	input wire logic FLAGS_WR,
	input wire logic [15:0] FLAGS_OUT,
	input wire logic STACK_WR,
	input wire logic [19:0] STACK_DATA,
	input wire logic PRIO_WR,
	input wire logic FETCH_START
);
	// Start-up wait plus the wake edge and the acknowledge register
	localparam int OSC_MAX = OSC_STABLE_CYCLES + 4;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	// ==========================================
	// Modes
	property p_stop_halt;
		ALL_CLOCK_STOP_CONTROL |-> !MAIN_OSC_EN && !SUB_OSC_EN && !PERIPH_CLK_EN && !BCLK_EN
			&& CPU_HALT;
	endproperty
	a_stop_halt: assert property (p_stop_halt) else $error("clock running in stop");
	property p_wait_osc;
		CPU_HALT && !ALL_CLOCK_STOP_CONTROL |-> SUB_OSC_EN && !BCLK_EN;
	endproperty
	a_wait_osc: assert property (p_wait_osc) else $error("oscillator off in wait");
	property p_stop_div8;
		$rose(ALL_CLOCK_STOP_CONTROL) && !SYSTEM_CLOCK_SOURCE_SELECT |-> ##[1:2] MAIN_DIV8_SELECT;
	endproperty
	a_stop_div8: assert property (p_stop_div8) else $error("divide-by-8 not forced");
	property p_stop_wake;
		$fell(ALL_CLOCK_STOP_CONTROL) |-> SUB_OSC_EN && CPU_HALT ##[1:OSC_MAX] ACK_RD;
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("no entry after stop wake");
	property p_key_wake;
		CPU_HALT && KEY_REQ |-> ##[1:OSC_MAX] ACK_RD;
	endproperty
	a_key_wake: assert property (p_key_wake) else $error("key request did not wake");
	property p_gated_hold;
		ALL_CLOCK_STOP_CONTROL && !(|INT_PIN_REQ) && !KEY_REQ && !(|(SERIAL_REQ & SERIAL_EXT_CLK))
			&& !(|(TIMER_REQ & TIMER_EXT_EVENT)) && NMI_N && $past(NMI_N, 5)
			|=> ALL_CLOCK_STOP_CONTROL;
	endproperty
	a_gated_hold: assert property (p_gated_hold) else $error("stop left without cause");
	property p_cfg_mirror;
		CLK_CFG_WR && !CPU_HALT |-> ##2 MAIN_DIVIDE_RATIO_LOW == $past(CFG_RATIO_LOW, 2);
	endproperty
	a_cfg_mirror: assert property (p_cfg_mirror) else $error("ratio bit not loaded");
	// ==========================================
	// Interrupt entry
	property p_ack_addr;
		ACK_RD |-> ACK_ADDR == pmc_pkg::ACK_ADDR;
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("acknowledge address wrong");
	property p_entry_seq;
		ACK_RD |-> ##3 FLAGS_WR ##1 STACK_WR [*2] ##1 (PRIO_WR && FETCH_START);
	endproperty
	a_entry_seq: assert property (p_entry_seq) else $error("entry steps out of order");
	property p_flg_clear;
		FLAGS_WR |-> !FLAGS_OUT[pmc_pkg::FLAGS_I_BIT] && !FLAGS_OUT[pmc_pkg::FLAGS_D_BIT];
	endproperty
	a_flg_clear: assert property (p_flg_clear) else $error("flags not cleared");
	property p_push_flags;
		FLAGS_WR |=> STACK_DATA[15:8] == FLAGS_OUT[15:8] && STACK_DATA[5:3] == FLAGS_OUT[5:3]
			&& STACK_DATA[1:0] == FLAGS_OUT[1:0] && STACK_DATA[19:16] == 4'h0;
	endproperty
	a_push_flags: assert property (p_push_flags) else $error("pushed flags differ");
endmodule // pmc_ctrl_sva

bind pmc_ctrl pmc_ctrl_sva #(.OSC_STABLE_CYCLES(OSC_STABLE_CYCLES)) i_pmc_ctrl_sva (
	.REF_CLK, .RESET, .NMI_N, .CLK_CFG_WR, .CFG_RATIO_LOW, .INT_PIN_REQ, .KEY_REQ, .SERIAL_REQ,
	.SERIAL_EXT_CLK, .TIMER_REQ, .TIMER_EXT_EVENT, .BCLK_EN, .CPU_HALT, .MAIN_OSC_EN, .SUB_OSC_EN,
	.PERIPH_CLK_EN, .ALL_CLOCK_STOP_CONTROL, .MAIN_DIV8_SELECT, .MAIN_DIVIDE_RATIO_LOW,
	.SYSTEM_CLOCK_SOURCE_SELECT, .ACK_RD, .ACK_ADDR, .FLAGS_WR, .FLAGS_OUT, .STACK_WR,
	.STACK_DATA, .PRIO_WR, .FETCH_START);

// file: test/pmc_cpu_model.sv
// Behavioural CPU core and sub oscillator beside the power-mode controller
`timescale 1ns/100ps
module pmc_cpu_model #(
	parameter logic [15:0] FLAGS = 16'h0040,
	parameter logic [19:0] PC = 20'h00000,
	parameter logic [2:0] LEVEL = 3'h1
) (
	// Clocking
	input wire logic ref_clk,
	input wire logic sub_osc_en,
	// Acknowledge
	input wire logic ack_rd,
	input wire logic [5:0] num,
	output logic subclock_signal,
	output logic [5:0] ack_num,
	output logic [2:0] ack_level,
	// Context
	output logic [15:0] flags_in,
	output logic [19:0] pc_in
);
	logic [2:0] div_reg = 3'h0;
	logic sub_reg = 1'b0;
	// Sub oscillator at one sixteenth of the reference; it freezes low while stopped
	always @(posedge ref_clk) begin
		div_reg <= sub_osc_en ? div_reg + 3'h1 : 3'h0;
		if (!sub_osc_en) begin
			sub_reg <= 1'b0;
		end else if (div_reg == 3'h7) begin
			sub_reg <= ~sub_reg;
		end
	end
	assign subclock_signal = sub_reg;
	// Outside the read the bus shows the inverse so stale data cannot pass
	assign ack_num = ack_rd ? num : ~num;
	// Request level sits above the base priority level zero
	assign ack_level = ack_rd ? LEVEL : ~LEVEL;
	// Interrupt enable flag is set before any low-power command
	assign flags_in = FLAGS;
	assign pc_in = PC;
endmodule // pmc_cpu_model

// file: test/testbench.sv
// Self-checking bench of the power-mode controller
`timescale 1ns/100ps
module testbench;
	localparam logic [15:0] FLAGS_V = 16'h5AC4;
	localparam logic [19:0] PC_V = 20'hABCDE;
	localparam logic [2:0] LVL = 3'h5;
	logic REF_CLK, RESET, CLK_EN, NMI_N, CLK_CFG_WR, WAIT_CMD, STOP_CMD, KEY_REQ;
	logic AD_REQ, AD_ONE_SHOT, SW_INT, CFG_SOURCE_SELECT, CFG_DIV8_SELECT, CFG_RATIO_LOW;
	logic CFG_RATIO_HIGH, CFG_WAIT_PCS, CFG_MAIN_STOP, CFG_MAIN_DRIVE, CFG_SUB_DRIVE;
	logic SUBCLOCK_SIGNAL, BCLK_EN, CPU_HALT, MAIN_OSC_EN, SUB_OSC_EN, PERIPH_CLK_EN;
	logic SUB_PERIPH_CLK_EN, MAIN_DRIVE_HIGH, SUB_DRIVE_HIGH, ALL_CLOCK_STOP_CONTROL;
	logic MAIN_DIV8_SELECT, MAIN_DIVIDE_RATIO_LOW, MAIN_DIVIDE_RATIO_HIGH, WAIT_PERIPH_CLOCK_STOP;
	logic SYSTEM_CLOCK_SOURCE_SELECT, ACK_RD, FLAGS_WR, STACK_WR, PRIO_WR, FETCH_START;
	logic [5:0] INT_PIN_REQ, ACK_NUM, num_v;
	logic [8:0] SERIAL_REQ, SERIAL_EXT_CLK;
	logic [10:0] TIMER_REQ, TIMER_EXT_EVENT;
	logic [2:0] ACK_LEVEL, PRIO_OUT;
	logic [15:0] FLAGS_IN, FLAGS_OUT;
	logic [19:0] PC_IN, ACK_ADDR, STACK_DATA;
	int n_mismatch, total_checks, cyc;
	// Short start-up count keeps the stop scenarios brief
	pmc_ctrl #(.OSC_STABLE_CYCLES(4)) i_pmc_ctrl (
		.REF_CLK, .RESET, .CLK_EN, .SUBCLOCK_SIGNAL, .NMI_N, .CLK_CFG_WR, .CFG_SOURCE_SELECT,
		.CFG_DIV8_SELECT, .CFG_RATIO_LOW, .CFG_RATIO_HIGH, .CFG_WAIT_PCS, .CFG_MAIN_STOP,
		.CFG_MAIN_DRIVE, .CFG_SUB_DRIVE, .WAIT_CMD, .STOP_CMD, .INT_PIN_REQ, .KEY_REQ, .SERIAL_REQ,
		.SERIAL_EXT_CLK, .TIMER_REQ, .TIMER_EXT_EVENT, .AD_REQ, .AD_ONE_SHOT, .ACK_NUM, .ACK_LEVEL,
		.SW_INT, .FLAGS_IN, .PC_IN, .BCLK_EN, .CPU_HALT, .MAIN_OSC_EN, .SUB_OSC_EN, .PERIPH_CLK_EN,
		.SUB_PERIPH_CLK_EN, .MAIN_DRIVE_HIGH, .SUB_DRIVE_HIGH, .ALL_CLOCK_STOP_CONTROL,
		.MAIN_DIV8_SELECT, .MAIN_DIVIDE_RATIO_LOW, .MAIN_DIVIDE_RATIO_HIGH,
		.SYSTEM_CLOCK_SOURCE_SELECT, .WAIT_PERIPH_CLOCK_STOP, .ACK_RD, .ACK_ADDR, .FLAGS_WR,
		.FLAGS_OUT, .STACK_WR, .STACK_DATA, .PRIO_WR, .PRIO_OUT, .FETCH_START);
	pmc_cpu_model #(.FLAGS(FLAGS_V), .PC(PC_V), .LEVEL(LVL)) i_pmc_cpu_model (
		.ref_clk(REF_CLK), .sub_osc_en(SUB_OSC_EN), .ack_rd(ACK_RD), .num(num_v),
		.subclock_signal(SUBCLOCK_SIGNAL), .ack_num(ACK_NUM), .ack_level(ACK_LEVEL),
		.flags_in(FLAGS_IN), .pc_in(PC_IN));
	// ==========================================
	// Common tasks
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick;
		@(posedge REF_CLK);
		#1;
	endtask
	task automatic cfg(logic [7:0] c);
		{CFG_SOURCE_SELECT, CFG_DIV8_SELECT, CFG_RATIO_HIGH, CFG_RATIO_LOW, CFG_WAIT_PCS,
			CFG_MAIN_STOP, CFG_MAIN_DRIVE, CFG_SUB_DRIVE} = c;
		CLK_CFG_WR = 1'b1;
		tick;
		CLK_CFG_WR = 1'b0;
		repeat (20) tick;
	endtask
	task automatic cmd(bit stop);
		STOP_CMD = stop;
		WAIT_CMD = !stop;
		tick;
		STOP_CMD = 1'b0;
		WAIT_CMD = 1'b0;
		repeat (2) tick;
	endtask
	// Kinds: pin, key, serial, serial ext, timer, timer ext, converter, converter one-shot, NMI
	task automatic req(int k, bit on);
		INT_PIN_REQ = (on && k == 0) ? 6'h20 : 6'h00;
		KEY_REQ = on && k == 1;
		SERIAL_REQ = (on && (k == 2 || k == 3)) ? 9'h101 : 9'h000;
		SERIAL_EXT_CLK = (on && k == 3) ? 9'h101 : 9'h000;
		TIMER_REQ = (on && (k == 4 || k == 5)) ? 11'h401 : 11'h000;
		TIMER_EXT_EVENT = (on && k == 5) ? 11'h401 : 11'h000;
		AD_REQ = on && (k == 6 || k == 7);
		AD_ONE_SHOT = on && k == 7;
		NMI_N = !(on && k == 8);
	endtask
	task automatic wait_ack(output bit s);
		s = 1'b0;
		repeat (16) if (!s) begin
			tick;
			s = (ACK_RD === 1'b1);
		end
	endtask
	task automatic cnt(int e);
		int n;
		n = 0;
		repeat (64) begin
			tick;
			n += BCLK_EN;
		end
		chk("bclk pulses", n, e);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_div;
		logic [7:0] c [6] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h43, 8'h83};
		int e [6] = '{64, 32, 16, 4, 8, 4};
		for (int i = 0; i < 6; i++) begin
			cfg(c[i]);
			cnt(e[i]);
		end
	endtask
	task automatic t_power;
		cfg(8'h87);
		chk("main osc", MAIN_OSC_EN, 0);
		chk("periph clocks", {PERIPH_CLK_EN, SUB_PERIPH_CLK_EN}, 1);
		cfg(8'h00);
		chk("drive", {MAIN_OSC_EN, MAIN_DRIVE_HIGH, SUB_DRIVE_HIGH}, 4);
		cfg(8'h03);
		chk("drive", {MAIN_DRIVE_HIGH, SUB_DRIVE_HIGH}, 3);
	endtask
	task automatic t_wake;
		bit s, w;
		for (int m = 0; m < 3; m++) begin
			for (int k = 0; k < 9; k++) begin
				cfg({4'h2, m == 1, 3'h3});
				cmd(m == 2);
				chk("halted", {CPU_HALT, ALL_CLOCK_STOP_CONTROL}, {1'b1, m == 2});
				chk("wait clocks", {PERIPH_CLK_EN, WAIT_PERIPH_CLOCK_STOP},
					{m == 0, m == 1});
				w = (k < 2 || k == 3 || k == 5 || k == 8) || (k != 6 && m == 0);
				req(k, 1);
				wait_ack(s);
				chk("woken", s, w);
				req(k, 0);
				if (!s) begin
					req(0, 1);
					wait_ack(s);
					req(0, 0);
				end
				repeat (12) tick;
				// Wait resumes the old divide-by-4; stop from main comes back at divide-by-8
				cnt((m == 2) ? 8 : 16);
			end
		end
	endtask
	task automatic t_stopclk(logic [7:0] c, logic [3:0] e);
		bit s;
		cfg(c);
		cmd(1);
		chk("osc off", {MAIN_OSC_EN, SUB_OSC_EN}, 0);
		req(1, 1);
		wait_ack(s);
		req(1, 0);
		chk("stop cleared", {s, ALL_CLOCK_STOP_CONTROL, SUB_OSC_EN}, 5);
		repeat (12) tick;
		chk("clock bits", {SYSTEM_CLOCK_SOURCE_SELECT, MAIN_DIV8_SELECT, MAIN_DIVIDE_RATIO_HIGH,
			MAIN_DIVIDE_RATIO_LOW}, e);
	endtask
	task automatic t_entry(logic [5:0] num, bit sw);
		bit s;
		logic [15:0] f;
		f = (sw && num >= 6'h20) ? 16'h5A80 : 16'h5A00;
		num_v = num;
		SW_INT = sw;
		cmd(0);
		req(0, 1);
		wait_ack(s);
		req(0, 0);
		chk("ack read", s, 1);
		repeat (3) tick;
		chk("flags out", {FLAGS_WR, FLAGS_OUT}, {1'b1, f});
		tick;
		chk("stack flags", {STACK_WR, STACK_DATA}, {1'b1, 4'h0, FLAGS_V});
		tick;
		chk("stack pc", {STACK_WR, STACK_DATA}, {1'b1, PC_V});
		tick;
		chk("priority", {PRIO_WR, FETCH_START, PRIO_OUT}, {2'h3, LVL});
		repeat (4) tick;
	endtask
	// ==========================================
	// Clock, timeout and main sequence
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			end_of_test;
		end
	end
	initial begin
		n_mismatch = 0;
		total_checks = 0;
		cyc = 0;
		RESET = 1'b1;
		CLK_EN = 1'b1;
		CLK_CFG_WR = 1'b0;
		WAIT_CMD = 1'b0;
		STOP_CMD = 1'b0;
		SW_INT = 1'b0;
		num_v = 6'h00;
		{CFG_SOURCE_SELECT, CFG_DIV8_SELECT, CFG_RATIO_HIGH, CFG_RATIO_LOW} = 4'h0;
		{CFG_WAIT_PCS, CFG_MAIN_STOP, CFG_MAIN_DRIVE, CFG_SUB_DRIVE} = 4'h3;
		req(0, 0);
		repeat (10) tick;
		RESET = 1'b0;
		t_div;
		t_power;
		t_wake;
		t_stopclk(8'h13, 4'h5);
		t_stopclk(8'h93, 4'h9);
		t_entry(6'h1F, 1);
		t_entry(6'h20, 1);
		t_entry(6'h3F, 1);
		t_entry(6'h20, 0);
		end_of_test;
	end
endmodule // testbench
